// *** rtl/acr_pkg.sv ***
// shared constants, types and lookups for the adc config register bank
package acr_pkg;
	localparam int ACR_NREG = 14; // subaddresses 0000..1101
	localparam logic [3:0] IDX_CONTROL = 4'h9;
	localparam logic [3:0] IDX_OSC = 4'ha;
	localparam logic [3:0] IDX_DIV = 4'hb;
	localparam logic [3:0] IDX_PHASE_A = 4'hc;
	localparam logic [3:0] IDX_PHASE_B = 4'hd;
	localparam logic [3:0] IDX_LAST = 4'hd;
	// power-up contents, index 0 first
	localparam logic [7:0] RST_VAL [ACR_NREG] = '{
		8'h7f, 8'h20, 8'h00, 8'h7f, 8'h20, 8'h00, 8'h7f,
		8'h20, 8'h00, 8'h04, 8'h61, 8'h90, 8'h00, 8'h00};
	// control register fields
	localparam int CTL_VLEVEL = 7;
	localparam int CTL_HLEVEL = 6;
	localparam int CTL_EDGE = 5;
	localparam int CTL_UP = 4;
	localparam int CTL_DN = 3;
	// oscillator register fields
	localparam int OSC_Z_LSB = 5;
	localparam int OSC_G_LSB = 3;
	// phase register fields
	localparam int PH_CLK_SEL = 5;
	localparam int PH_CODE_W = 5;
	// serial slave address upper bits and subaddress mode bit
	localparam logic [4:0] DEV_ADDR_HI = 5'h13;
	localparam int SUB_MODE_BIT = 4;
	localparam logic [15:0] PHASE_STEP_CDEG = 16'h0465; // 11.25 deg
	localparam logic [9:0] FINE_BASE = 10'h200; // 512
	localparam logic [10:0] DIV_RST = 11'h190;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	typedef enum logic [1:0] {
		ACR_IDLE = 2'b00,
		ACR_RECV = 2'b01,
		ACR_ACK = 2'b10,
		ACR_SKIP = 2'b11
	} acr_state_t;
	typedef enum logic [1:0] {
		ACR_B_ADDR = 2'b00,
		ACR_B_SUB = 2'b01,
		ACR_B_DATA = 2'b10
	} acr_byte_t;
	// charge pump current in quarter microamps
	function automatic logic [11:0] acr_pump_qua(input logic [2:0] c);
		case (c)
			3'h0: acr_pump_qua = 12'h019;
			3'h1: acr_pump_qua = 12'h032;
			3'h2: acr_pump_qua = 12'h064;
			3'h3: acr_pump_qua = 12'h0c8;
			3'h4: acr_pump_qua = 12'h190;
			3'h5: acr_pump_qua = 12'h320;
			3'h6: acr_pump_qua = 12'h640;
			default: acr_pump_qua = 12'haf0;
		endcase
	endfunction
	// filter resistance in kilohm, zero for open
	function automatic logic [7:0] acr_filter_k(input logic [2:0] c);
		acr_filter_k = (c == 3'h0) ? 8'h00 : 8'h80 >> (c + 3'h1 - 3'h1
			+ ((c == 3'h1) ? 3'h0 : 3'h1) - 3'h1);
	endfunction
	// oscillator gain in mhz per volt
	function automatic logic [6:0] acr_osc_mhz(input logic [1:0] c);
		case (c)
			2'h0: acr_osc_mhz = 7'h0f;
			2'h1: acr_osc_mhz = 7'h1e;
			2'h2: acr_osc_mhz = 7'h3c;
			default: acr_osc_mhz = 7'h64;
		endcase
	endfunction
endpackage

// *** rtl/acr_wire_shift.sv ***
// three-wire receive shifter, runs on the wire clock
`timescale 1ns/100ps
module acr_wire_shift #(
	parameter int WORD_W = 16
) (
	input wire logic wire_clk,
	input wire logic serial_enable_pin,
	input wire logic wire_data,
	output logic [WORD_W-1:0] word,
	output logic word_done
);
	logic [4:0] cnt; // bits taken this frame

	// the enable pin clears the frame; the wire clock may stop between
	// frames so nothing here waits for an edge after the last bit
	always_ff @(posedge wire_clk or negedge serial_enable_pin) begin
		if (!serial_enable_pin) begin
			cnt <= 5'h00;
			word <= '0;
			word_done <= 1'b0;
		end else if (!word_done) begin
			// msb first, subaddress byte then data byte
			word <= {word[WORD_W-2:0], wire_data};
			cnt <= cnt + 5'h01;
			// word then stands until the enable drops
			if (cnt == 5'(WORD_W - 1)) begin
				word_done <= 1'b1;
			end
		end
	end
endmodule

// *** rtl/acr_top.sv ***
// serial configuration register bank with two-wire and three-wire ports
// Summary of operation
// - gain numerator coarse+1, denominator 512-fine
// - level bits invert coast and hsync inputs
// - edge bit picks rising or falling reference
// - current field maps to eight pump currents
// - control resets to 100 ua, rising, active high
// - resistance field selects open or 128..1 kohm
// - gain field gives 15, 30, 60, 100
// - oscillator resets to 16 kohm, 15 mhz/v
// - divider is three high plus eight low
// - clock a select: pll or external
// - clock b enable clear means unused
// - phase equals code times 11.25 degrees
// - phase registers reset to zero
// - answer address 10011 with write direction
// - address bits two and one from pins
// - mode zero: subaddress, data pairs, acked
// - mode one: data bytes fill successive registers
// - three-wire accepted only while enable valid
// - subaddress bit four mode, bits three..zero
// - sequential load runs 0000 up to 1101
// - disable pin high shuts serial interface
`timescale 1ns/100ps
module acr_top
	import acr_pkg::*;
#(
	parameter int NCH = 3
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	input wire logic addr_select_low,
	input wire logic addr_select_high,
	input wire logic interface_disable_pin,
	input wire logic wire_mode_sel,
	input wire logic wire_clk,
	input wire logic wire_data,
	input wire logic serial_enable_pin,
	input wire logic coast_in,
	input wire logic hsync_in,
	input wire logic pll_reference_clock,
	output logic [NCH-1:0][7:0] gain_numer,
	output logic [NCH-1:0][9:0] gain_denom,
	output logic coast_active,
	output logic hsync_active,
	output logic ref_sync_pulse,
	output logic pump_force_up,
	output logic pump_force_down,
	output logic [2:0] pump_current_sel,
	output logic [11:0] pump_current_qua,
	output logic [2:0] filter_resistance_sel,
	output logic [7:0] filter_kohm,
	output logic [1:0] oscillator_gain_sel,
	output logic [6:0] oscillator_gain_mhz,
	output logic [10:0] pll_divide_value,
	output logic converter_clock_source,
	output logic phase_b_clock_enable,
	output logic [4:0] phase_a_code,
	output logic [4:0] phase_b_code,
	output logic [15:0] phase_a_cdeg,
	output logic [15:0] phase_b_cdeg
);
	localparam int NSYNC = 11;
	// bus pins idle high; clearing their stages would fake an edge
	localparam logic [NSYNC-1:0] SYNC_IDLE = 11'h003;
	logic [NSYNC-1:0] raw; // pins and the link flag before sync
	logic [NSYNC-1:0] sy1; // first stage, read by sy2 only
	logic [NSYNC-1:0] sy2; // usable synchronised levels
	logic scl_p, sda_p; // previous synced bus levels
	logic ref_p; // previous synced reference level
	logic done_p; // previous synced link flag
	logic [7:0] regs [ACR_NREG]; // register storage
	logic [15:0] wword; // link word, stable while flag high
	logic wdone; // link word ready, link domain level
	acr_state_t state;
	acr_byte_t which; // which byte of the frame comes next
	logic [7:0] shreg; // incoming byte
	logic [3:0] bcnt; // bits of the byte so far
	logic [3:0] ptr; // register pointer
	logic seq; // sequential mode latched
	logic s_scl, s_sda, s_alo, s_ahi, s_dis, s_wsel, s_sen;
	logic s_coast, s_hsync, s_ref, s_done;
	logic i2c_on, wire_on, scl_rise, scl_fall, start, stop;
	logic byte_done, ack_ok, addr_hit, wire_take;
	logic wr_en;
	logic [3:0] wr_idx;
	logic [7:0] wr_data;

	assign raw = {wdone, pll_reference_clock, hsync_in, coast_in,
		serial_enable_pin, wire_mode_sel, interface_disable_pin,
		addr_select_high, addr_select_low, sda_in, scl_in};
	assign {s_done, s_ref, s_hsync, s_coast, s_sen, s_wsel, s_dis,
		s_ahi, s_alo, s_sda, s_scl} = sy2;

	// link-side shifter on its own clock
	acr_wire_shift #(.WORD_W(16)) u_wire (
		.wire_clk(wire_clk),
		.serial_enable_pin(serial_enable_pin),
		.wire_data(wire_data),
		.word(wword),
		.word_done(wdone)
	);

	// two-flop synchronisers, one per asynchronous input
	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_sync
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					sy1[gi] <= SYNC_IDLE[gi];
					sy2[gi] <= SYNC_IDLE[gi];
				end else begin
					sy1[gi] <= raw[gi];
					sy2[gi] <= sy1[gi];
				end
			end
		end
	endgenerate

	// delayed copies for edge detection, taken from the second stage
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			scl_p <= 1'b1;
			sda_p <= 1'b1;
			ref_p <= 1'b0;
			done_p <= 1'b0;
		end else begin
			scl_p <= s_scl;
			sda_p <= s_sda;
			ref_p <= s_ref;
			done_p <= s_done;
		end
	end

	// port selection; the disable pin wins over both
	assign i2c_on = !s_dis && !s_wsel;
	assign wire_on = !s_dis && s_wsel && s_sen;
	assign scl_rise = s_scl && !scl_p;
	assign scl_fall = !s_scl && scl_p;
	// data moving while the clock is high frames a transfer
	assign start = s_scl && scl_p && sda_p && !s_sda;
	assign stop = s_scl && scl_p && !sda_p && s_sda;
	assign byte_done = (state == ACR_RECV) && scl_fall
		&& (bcnt == BITS_PER_BYTE);
	// fixed upper address, pins give the next two, write only
	assign addr_hit = (shreg[7:1] == {DEV_ADDR_HI, s_ahi, s_alo})
		&& !shreg[0];
	assign ack_ok = (which != ACR_B_ADDR) || addr_hit;
	// a link word counts once, on its flag rising, if still enabled
	assign wire_take = s_done && !done_p && wire_on;

	// bit-level slave machine
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state <= ACR_IDLE;
			shreg <= 8'h00;
			bcnt <= 4'h0;
			sda_oe_n <= 1'b1;
		end else if (!i2c_on) begin
			// released at once; a disabled part never holds the line
			state <= ACR_IDLE;
			sda_oe_n <= 1'b1;
		end else if (start) begin
			state <= ACR_RECV;
			bcnt <= 4'h0;
			sda_oe_n <= 1'b1;
		end else if (stop) begin
			state <= ACR_IDLE;
			sda_oe_n <= 1'b1;
		end else begin
			case (state)
				ACR_RECV: begin
					if (scl_rise && bcnt != BITS_PER_BYTE) begin
						shreg <= {shreg[6:0], s_sda};
						bcnt <= bcnt + 4'h1;
					end else if (byte_done) begin
						// every byte acked, foreign or read address not
						if (ack_ok) begin
							sda_oe_n <= 1'b0;
							state <= ACR_ACK;
						end else begin
							state <= ACR_SKIP;
						end
					end
				end
				ACR_ACK: begin
					// hold low through the ninth clock
					if (scl_fall) begin
						sda_oe_n <= 1'b1;
						bcnt <= 4'h0;
						state <= ACR_RECV;
					end
				end
				ACR_SKIP: begin
					// wait for the next start or stop
					state <= ACR_SKIP;
				end
				default: begin
					state <= ACR_IDLE;
				end
			endcase
		end
	end

	// the driven level is always low; only the enable moves
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sda_out <= 1'b0;
		end else begin
			sda_out <= 1'b0;
		end
	end

	// byte sequencing and register pointer
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			which <= ACR_B_ADDR;
			ptr <= 4'h0;
			seq <= 1'b0;
		end else if (start || !i2c_on) begin
			which <= ACR_B_ADDR;
			seq <= 1'b0;
		end else if (byte_done && ack_ok) begin
			case (which)
				ACR_B_ADDR: begin
					which <= ACR_B_SUB;
				end
				ACR_B_SUB: begin
					which <= ACR_B_DATA;
					// mode bit set starts the fixed walk at zero
					seq <= shreg[SUB_MODE_BIT];
					ptr <= shreg[SUB_MODE_BIT] ? 4'h0
						: shreg[3:0];
				end
				ACR_B_DATA: begin
					// mode one walks on, mode zero expects a subaddress
					if (seq) begin
						if (ptr != 4'hf) begin
							ptr <= ptr + 4'h1;
						end
					end else begin
						which <= ACR_B_SUB;
					end
				end
				default: begin
					which <= ACR_B_ADDR;
				end
			endcase
		end
	end

	// one write port shared by both serial ports
	always_comb begin
		wr_en = 1'b0;
		wr_idx = ptr;
		wr_data = shreg;
		if (wire_take) begin
			wr_en = (wword[11:8] <= IDX_LAST);
			wr_idx = wword[11:8];
			wr_data = wword[7:0];
		end else if (byte_done && which == ACR_B_DATA) begin
			// data past the last register is acked and dropped
			wr_en = (ptr <= IDX_LAST);
		end
	end

	// register storage, power-up defaults from the table
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int i = 0; i < ACR_NREG; i++) begin
				regs[i] <= RST_VAL[i];
			end
		end else if (wr_en) begin
			regs[wr_idx] <= wr_data;
		end
	end

	// divide ratio moves only with the low byte, so the upper bits
	// written earlier never reach the loop on their own
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pll_divide_value <= DIV_RST;
		end else if (wr_en && wr_idx == IDX_DIV) begin
			pll_divide_value <= {regs[IDX_OSC][2:0], wr_data};
		end
	end

	// per-channel gain terms: gain = numer * 32 / (2.5 v * denom)
	generate
		for (gi = 0; gi < NCH; gi++) begin : g_gain
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					gain_numer[gi] <= 8'h00;
					gain_denom[gi] <= FINE_BASE;
				end else begin
					gain_numer[gi] <= {1'b0, regs[3*gi+1][6:0]}
						+ 8'h01;
					gain_denom[gi] <= FINE_BASE
						- {5'h00, regs[3*gi+2][4:0]};
				end
			end
		end
	endgenerate

	// sync polarity and reference edge
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			coast_active <= 1'b0;
			hsync_active <= 1'b0;
			ref_sync_pulse <= 1'b0;
		end else begin
			coast_active <= s_coast ^ regs[IDX_CONTROL][CTL_VLEVEL];
			hsync_active <= s_hsync ^ regs[IDX_CONTROL][CTL_HLEVEL];
			ref_sync_pulse <= regs[IDX_CONTROL][CTL_EDGE]
				? (ref_p && !s_ref) : (!ref_p && s_ref);
		end
	end

	// pump, filter and oscillator settings with decoded values
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pump_force_up <= 1'b0;
			pump_force_down <= 1'b0;
			pump_current_sel <= 3'h0;
			pump_current_qua <= 12'h000;
			filter_resistance_sel <= 3'h0;
			filter_kohm <= 8'h00;
			oscillator_gain_sel <= 2'h0;
			oscillator_gain_mhz <= 7'h00;
		end else begin
			// test forcing passes through; zero is the master's duty
			pump_force_up <= regs[IDX_CONTROL][CTL_UP];
			pump_force_down <= regs[IDX_CONTROL][CTL_DN];
			pump_current_sel <= regs[IDX_CONTROL][2:0];
			pump_current_qua <= acr_pump_qua(regs[IDX_CONTROL][2:0]);
			filter_resistance_sel <= regs[IDX_OSC][OSC_Z_LSB+:3];
			filter_kohm <= acr_filter_k(regs[IDX_OSC][OSC_Z_LSB+:3]);
			oscillator_gain_sel <= regs[IDX_OSC][OSC_G_LSB+:2];
			oscillator_gain_mhz <=
				acr_osc_mhz(regs[IDX_OSC][OSC_G_LSB+:2]);
		end
	end

	// clock source, second clock and phase shifts
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			converter_clock_source <= 1'b0;
			phase_b_clock_enable <= 1'b0;
			phase_a_code <= 5'h00;
			phase_b_code <= 5'h00;
			phase_a_cdeg <= 16'h0000;
			phase_b_cdeg <= 16'h0000;
		end else begin
			converter_clock_source <= regs[IDX_PHASE_A][PH_CLK_SEL];
			phase_b_clock_enable <= regs[IDX_PHASE_B][PH_CLK_SEL];
			phase_a_code <= regs[IDX_PHASE_A][PH_CODE_W-1:0];
			phase_b_code <= regs[IDX_PHASE_B][PH_CODE_W-1:0];
			phase_a_cdeg <= 16'(regs[IDX_PHASE_A][PH_CODE_W-1:0]
				* PHASE_STEP_CDEG);
			phase_b_cdeg <= 16'(regs[IDX_PHASE_B][PH_CODE_W-1:0]
				* PHASE_STEP_CDEG);
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	property p_addr_ack;
		byte_done && which == ACR_B_ADDR && addr_hit && i2c_on
			&& !start && !stop |=> !sda_oe_n;
	endproperty
	a_addr_ack: assert property (p_addr_ack)
		else $error("matching address not acknowledged");

	property p_read_nack;
		byte_done && which == ACR_B_ADDR && shreg[0]
			|=> sda_oe_n [*2];
	endproperty
	a_read_nack: assert property (p_read_nack)
		else $error("read address drove the data line");

	property p_div_hold;
		!(wr_en && wr_idx == IDX_DIV) |=> $stable(pll_divide_value);
	endproperty
	a_div_hold: assert property (p_div_hold)
		else $error("divider changed without low byte write");

	property p_div_load;
		wr_en && wr_idx == IDX_DIV |=> pll_divide_value
			== {$past(regs[IDX_OSC][2:0]), $past(wr_data)};
	endproperty
	a_div_load: assert property (p_div_load)
		else $error("divider not formed from both parts");

	property p_seq_start;
		byte_done && which == ACR_B_SUB && shreg[SUB_MODE_BIT]
			&& i2c_on && !start |=> ptr == 4'h0 && seq;
	endproperty
	a_seq_start: assert property (p_seq_start)
		else $error("sequential load did not start at zero");

	property p_disable;
		s_dis |=> sda_oe_n && state == ACR_IDLE && !wr_en;
	endproperty
	a_disable: assert property (p_disable)
		else $error("disabled interface still active");

	property p_wire_en;
		wr_en && !byte_done |-> s_sen && s_wsel;
	endproperty
	a_wire_en: assert property (p_wire_en)
		else $error("link write without enable");

	property p_edge;
		!regs[IDX_CONTROL][CTL_EDGE] && s_ref && !ref_p
			&& $stable(regs[IDX_CONTROL]) |=> ref_sync_pulse;
	endproperty
	a_edge: assert property (p_edge)
		else $error("rising reference edge missed");

	property p_phase;
		##1 phase_a_cdeg == 16'($past(regs[IDX_PHASE_A][4:0])
			* PHASE_STEP_CDEG);
	endproperty
	a_phase: assert property (p_phase)
		else $error("phase shift not code times step");
endmodule

// *** verification/acr_master.sv ***
// bus master model for the two-wire and three-wire configuration ports
`timescale 1ns/100ps
module acr_master (
	input wire logic clk,
	input wire logic sda_line,
	output logic scl,
	output logic sda,
	output logic lclk,
	output logic ldat,
	output logic len
);
	// idle: two-wire released high, link clock standing still
	initial begin
		scl = 1'b1;
		sda = 1'b1;
		lclk = 1'b0;
		ldat = 1'b0;
		len = 1'b0;
	end
	// eight clocks, twice the four-clock minimum of the oversampler
	task automatic half();
		repeat (8) @(negedge clk);
	endtask
	// one bit cell; data only moves while the bus clock is low
	task automatic bit_cell(input logic d, output logic seen);
		sda = d;
		half();
		scl = 1'b1;
		half();
		seen = sda_line;
		scl = 1'b0;
		half();
	endtask
	// start, bytes each with a ninth answer bit, stop; counts acks
	task automatic xfer(input logic [7:0] b [16], input int n,
		output int acks);
		logic s;
		acks = 0;
		half();
		sda = 1'b0; // start: data falls while clock high
		half();
		scl = 1'b0;
		half();
		for (int i = 0; i < n; i++) begin
			for (int j = 7; j >= 0; j--) begin
				bit_cell(b[i][j], s);
			end
			bit_cell(1'b1, s);
			acks += (s === 1'b0);
		end
		sda = 1'b0;
		half();
		scl = 1'b1;
		half();
		sda = 1'b1; // stop: data rises while clock high
		half();
	endtask
	// one link frame at 160 ns a bit; en low leaves it unvalidated
	task automatic frame(input logic [15:0] w, input logic en);
		len = en;
		// odd lead so link edges never line up with the system clock
		#43;
		for (int i = 15; i >= 0; i--) begin
			ldat = w[i];
			#80 lclk = 1'b1;
			#80 lclk = 1'b0;
		end
		// data line is not held once the frame is over
		ldat = ~ldat;
		#40 len = 1'b0;
		#200;
	endtask
endmodule

// *** verification/testbench.sv ***
// self-checking bench for the configuration register bank
`timescale 1ns/100ps
module testbench;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic addr_select_low = 1'b0;
	logic addr_select_high = 1'b1;
	logic interface_disable_pin = 1'b0;
	logic wire_mode_sel = 1'b0;
	logic coast_in = 1'b1;
	logic hsync_in = 1'b0;
	logic pll_reference_clock = 1'b0;
	wire scl_in, sda_drv, wire_clk, wire_data, serial_enable_pin;
	wire sda_out, sda_oe_n, coast_active, hsync_active, ref_sync_pulse;
	wire pump_force_up, pump_force_down, converter_clock_source;
	wire phase_b_clock_enable;
	wire [2:0][7:0] gain_numer;
	wire [2:0][9:0] gain_denom;
	wire [2:0] pump_current_sel, filter_resistance_sel;
	wire [11:0] pump_current_qua;
	wire [7:0] filter_kohm;
	wire [1:0] oscillator_gain_sel;
	wire [6:0] oscillator_gain_mhz;
	wire [10:0] pll_divide_value;
	wire [4:0] phase_a_code, phase_b_code;
	wire [15:0] phase_a_cdeg, phase_b_cdeg;
	// pull-up: low when either party pulls the data line
	wire sda_in = sda_drv & (sda_oe_n | sda_out);
	// grouped views so one compare covers several fields at once
	wire [6:0] ctl_obs = {coast_active, hsync_active, pump_force_up,
		pump_force_down, pump_current_sel};
	wire [4:0] osc_obs = {filter_resistance_sel, oscillator_gain_sel};
	wire [11:0] ph_obs = {converter_clock_source, phase_b_clock_enable,
		phase_a_code, phase_b_code};
	logic [7:0] b [16];
	logic [7:0] adr = 8'h9c;
	int acks, up, dn;
	int failures = 0;
	int checks_done = 0;
	// expected decodes per field code
	logic [11:0] qua_tab [8] = '{12'h019, 12'h032, 12'h064, 12'h0c8,
		12'h190, 12'h320, 12'h640, 12'haf0};
	logic [7:0] kohm_tab [8] = '{8'h00, 8'h80, 8'h20, 8'h10, 8'h08,
		8'h04, 8'h02, 8'h01};
	logic [6:0] mhz_tab [4] = '{7'h0f, 7'h1e, 7'h3c, 7'h64};
	// wrong pin bit, wrong pin bit, wrong fixed bit, read direction
	logic [7:0] bad [4] = '{8'h9e, 8'h98, 8'h1c, 8'h9d};

	acr_master m (.clk(clk), .sda_line(sda_in), .scl(scl_in),
		.sda(sda_drv), .lclk(wire_clk), .ldat(wire_data),
		.len(serial_enable_pin));
	acr_top #(.NCH(3)) dut (.clk(clk), .rst_n(rst_n), .scl_in(scl_in),
		.sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
		.addr_select_low(addr_select_low),
		.addr_select_high(addr_select_high),
		.interface_disable_pin(interface_disable_pin),
		.wire_mode_sel(wire_mode_sel), .wire_clk(wire_clk),
		.wire_data(wire_data), .serial_enable_pin(serial_enable_pin),
		.coast_in(coast_in), .hsync_in(hsync_in),
		.pll_reference_clock(pll_reference_clock),
		.gain_numer(gain_numer), .gain_denom(gain_denom),
		.coast_active(coast_active), .hsync_active(hsync_active),
		.ref_sync_pulse(ref_sync_pulse), .pump_force_up(pump_force_up),
		.pump_force_down(pump_force_down),
		.pump_current_sel(pump_current_sel),
		.pump_current_qua(pump_current_qua),
		.filter_resistance_sel(filter_resistance_sel),
		.filter_kohm(filter_kohm),
		.oscillator_gain_sel(oscillator_gain_sel),
		.oscillator_gain_mhz(oscillator_gain_mhz),
		.pll_divide_value(pll_divide_value),
		.converter_clock_source(converter_clock_source),
		.phase_b_clock_enable(phase_b_clock_enable),
		.phase_a_code(phase_a_code), .phase_b_code(phase_b_code),
		.phase_a_cdeg(phase_a_cdeg), .phase_b_cdeg(phase_b_cdeg));

	// 100 mhz system clock
	always #5 clk = ~clk;

	// compare and count; four-state compare so unknowns never match
	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// verdict and end of run
	task automatic results();
		if (failures == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// one subaddress and data pair, all three bytes must be acked
	task automatic w2(input logic [7:0] sub, input logic [7:0] d);
		b[0] = adr;
		b[1] = sub;
		b[2] = d;
		m.xfer(b, 3, acks);
		check("acks", acks, 3);
	endtask
	// sync pulses seen over eight clocks after moving the reference
	task automatic ref_count(input logic lvl, output int n);
		n = 0;
		@(negedge clk);
		pll_reference_clock = lvl;
		repeat (8) begin
			@(negedge clk);
			n += (ref_sync_pulse === 1'b1);
		end
	endtask

	// hang guard: a stuck run counts as a mismatch
	initial begin
		#500000;
		failures++;
		results();
	end

	// main sequence
	initial begin
		repeat (4) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		// power-up contents through the decoded outputs
		for (int c = 0; c < 3; c++) begin
			check("numer", gain_numer[c], 16'h0021);
			check("denom", gain_denom[c], 16'h0200);
		end
		check("ctl", ctl_obs, 16'h0044);
		check("pump", pump_current_qua, 16'h0190);
		check("osc", osc_obs, 16'h000c);
		check("kohm", filter_kohm, 16'h0010);
		check("mhz", oscillator_gain_mhz, 16'h000f);
		check("div", pll_divide_value, 16'h0190);
		check("ph", ph_obs, 16'h0000);
		check("cdeg", phase_a_cdeg | phase_b_cdeg, 16'h0000);
		// every field code except the forcing bits, two registers per transfer
		for (int i = 0; i < 8; i++) begin
			b[0] = adr;
			b[1] = 8'h09;
			b[2] = {i[0], i[1], i[2], 2'b00, i[2:0]};
			b[3] = 8'h0a;
			b[4] = {i[2:0], i[1:0], 3'b001};
			m.xfer(b, 5, acks);
			check("acks", acks, 5);
			check("pump", pump_current_qua, qua_tab[i]);
			check("ctl", ctl_obs, {~i[0], i[1], 2'b00, i[2:0]});
			check("osc", osc_obs, {i[2:0], i[1:0]});
			check("kohm", filter_kohm, kohm_tab[i]);
			check("mhz", oscillator_gain_mhz, mhz_tab[i[1:0]]);
			ref_count(1'b1, up);
			ref_count(1'b0, dn);
			check("rise", up, !i[2]);
			check("fall", dn, i[2]);
		end
		// upper divider bits wait for the low byte
		w2(8'h0a, 8'h65);
		check("div", pll_divide_value, 16'h0190);
		w2(8'h0b, 8'h34);
		check("div", pll_divide_value, 16'h0534);
		w2(8'h0c, 8'h3f);
		w2(8'h0d, 8'h21);
		check("ph", ph_obs, 16'h0fe1);
		check("pha", phase_a_cdeg, 16'h883b);
		check("phb", phase_b_cdeg, 16'h0465);
		// sequential load of all fourteen registers
		b[0] = adr;
		b[1] = 8'hff;
		for (int k = 0; k < 14; k++) begin
			b[k + 2] = 8'(k);
		end
		b[11] = 8'h82;
		m.xfer(b, 16, acks);
		check("acks", acks, 16);
		for (int c = 0; c < 3; c++) begin
			check("numer", gain_numer[c], 16'(3 * c + 2));
			check("denom", gain_denom[c], 16'(510 - 3 * c));
		end
		check("pump", pump_current_qua, 16'h0064);
		check("div", pll_divide_value, 16'h020b);
		check("pha", phase_a_cdeg, 16'h34bc);
		check("phb", phase_b_cdeg, 16'h3921);
		// foreign addresses and reads get no answer and write nothing
		for (int k = 0; k < 4; k++) begin
			b[0] = bad[k];
			b[1] = 8'h01;
			b[2] = 8'h77;
			m.xfer(b, 3, acks);
			check("nack", acks, 0);
		end
		check("numer", gain_numer[0], 16'h0002);
		// two-wire port shut off by the disable pin
		interface_disable_pin = 1'b1;
		b[0] = adr;
		m.xfer(b, 3, acks);
		check("nack", acks, 0);
		interface_disable_pin = 1'b0;
		check("numer", gain_numer[0], 16'h0002);
		// other pin setting moves the address
		addr_select_low = 1'b1;
		addr_select_high = 1'b0;
		adr = 8'h9a;
		repeat (4) @(negedge clk);
		w2(8'h01, 8'h22);
		check("numer", gain_numer[0], 16'h0023);
		// three-wire port: valid frame, unvalidated, disabled
		wire_mode_sel = 1'b1;
		repeat (4) @(negedge clk);
		m.frame(16'h0130, 1'b1);
		check("numer", gain_numer[0], 16'h0031);
		m.frame(16'h0450, 1'b0);
		check("numer", gain_numer[1], 16'h0005);
		@(negedge clk);
		interface_disable_pin = 1'b1;
		m.frame(16'h0750, 1'b1);
		check("numer", gain_numer[2], 16'h0008);
		results();
	end
endmodule
